// file: rtl/dual_serial_host_port.sv
`timescale 1ns/1ps
module dual_serial_host_port
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // serial pins
   input wire logic i_cs_n,
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_dout_out,
   output logic o_dout_oe,
   input wire logic [1:0] i_addr_strap,
   // byte stream to and from the register side
   input wire logic [7:0] i_tx_byte,
   output logic o_tx_take,
   output rx_type o_rx,
   output logic [6:0] o_bus_addr,
   output logic o_addr_latched,
   // output load strobe and channel registers
   input wire logic i_output_load_strobe_n,
   input wire logic i_strobe_pin_enable_bit,
   input wire logic [NUM_CHAN-1:0] i_input_new,
   input wire chan_data_type i_input_data,
   output logic [NUM_CHAN-1:0] o_input_taken,
   output chan_data_type o_out_data,
   // limit interrupt
   input wire logic [2:0] i_limit_exceeded,
   input wire logic i_int_active_high,
   output logic o_int_out,
   output logic o_int_oe
);

   pin_bundle_type pins_raw; // pads as they arrive
   pin_bundle_type pins_s; // pads after two flops
   logic scl_d, sda_d, cs_d, load_d; // previous synced levels
   logic scl_rise, scl_fall, cs_fall, load_fall; // edge events
   logic i2c_on, spi_on, start_cond, stop_cond; // link mode and frame marks

   // two-wire slave state
   i2c_state_type state, next_state;
   logic [3:0] i2c_cnt, next_i2c_cnt;
   logic [7:0] i2c_shift, next_i2c_shift;
   logic sda_oe, next_sda_oe;
   logic rw, next_rw;
   logic flag, next_flag; // address match, later master ack
   logic i2c_fire, i2c_take, addr_hit;
   logic [7:0] i2c_byte;

   // address latch state
   logic [1:0] valid_cnt, next_valid_cnt;
   logic latched, next_latched;
   logic [6:0] held, next_held, addr_live, addr_eff;

   // four-wire shifter state
   logic [2:0] in_cnt, next_in_cnt, out_cnt, next_out_cnt;
   logic [7:0] spi_in, next_spi_in, spi_out, next_spi_out;
   logic dout_oe, next_dout_oe;
   logic spi_fire, spi_take;

   // output side registers
   rx_type next_rx;
   chan_data_type next_out_data;
   logic [NUM_CHAN-1:0] next_taken;
   logic next_int_oe;

   // all pads pass two flops before use
   assign pins_raw = {i_cs_n, i_scl, i_sda_in, i_output_load_strobe_n, i_addr_strap};

   sync_two_ff #(
      .WIDTH($bits(pin_bundle_type))
   ) u_pad_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async(pins_raw),
      .o_sync(pins_s)
   );

   // previous levels for edge detection
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         cs_d <= 1'b1;
         load_d <= 1'b1;
      end
      else
      begin
         scl_d <= pins_s.scl;
         sda_d <= pins_s.sda;
         cs_d <= pins_s.cs_n;
         load_d <= pins_s.load_n;
      end
   end

   // chip select steers the shared pins
   assign i2c_on = pins_s.cs_n;
   assign spi_on = ~pins_s.cs_n;
   // sampling at system rate covers both bus speeds
   assign scl_rise = pins_s.scl & ~scl_d;
   assign scl_fall = ~pins_s.scl & scl_d;
   assign cs_fall = cs_d & ~pins_s.cs_n;
   assign start_cond = i2c_on & pins_s.scl & scl_d & sda_d & ~pins_s.sda;
   assign stop_cond = i2c_on & pins_s.scl & scl_d & ~sda_d & pins_s.sda;
   assign i2c_byte = {i2c_shift[6:0], pins_s.sda};

   always_comb
   begin
      case (pins_s.strap)
         STRAP_LOW: addr_live = ADDR_STRAP_LOW;
         STRAP_FLOAT: addr_live = ADDR_STRAP_FLOAT;
         STRAP_HIGH: addr_live = ADDR_STRAP_HIGH;
         default: addr_live = ADDR_STRAP_FLOAT;
      endcase
   end

   // once latched the strap no longer matters
   assign addr_eff = latched ? held : addr_live;

   // two-wire slave next state
   always_comb
   begin
      next_state = state;
      next_i2c_cnt = i2c_cnt;
      next_i2c_shift = i2c_shift;
      next_sda_oe = sda_oe;
      next_rw = rw;
      next_flag = flag;
      i2c_fire = 1'b0;
      i2c_take = 1'b0;
      addr_hit = 1'b0;
      if (!i2c_on)
      begin
         // four-wire frame: two-wire side stays quiet
         next_state = I2C_IDLE;
         next_sda_oe = 1'b0;
      end
      else if (start_cond)
      begin
         next_state = I2C_ADDR;
         next_i2c_cnt = '0;
         next_sda_oe = 1'b0;
      end
      else if (stop_cond)
      begin
         next_state = I2C_IDLE;
         next_sda_oe = 1'b0;
      end
      else
      begin
         case (state)
            I2C_ADDR, I2C_WR:
            begin
               // shift in on rising clock
               if (scl_rise)
               begin
                  next_i2c_shift = i2c_byte;
                  next_i2c_cnt = i2c_cnt + 4'h1;
                  if (i2c_cnt == I2C_BIT_LAST && state == I2C_ADDR)
                  begin
                     next_flag = (i2c_shift[6:0] == addr_eff);
                     next_rw = pins_s.sda;
                     addr_hit = (i2c_shift[6:0] == addr_eff);
                  end
                  else if (i2c_cnt == I2C_BIT_LAST)
                  begin
                     i2c_fire = 1'b1;
                  end
               end
               // acknowledge slot after the eighth bit
               else if (scl_fall && i2c_cnt == I2C_ACK_SLOT)
               begin
                  if (state == I2C_WR || flag)
                  begin
                     next_sda_oe = 1'b1;
                     next_state = I2C_ACK;
                  end
                  else
                  begin
                     next_state = I2C_IDLE;
                  end
               end
            end
            I2C_ACK, I2C_RACK:
            begin
               // master acknowledge after a read byte
               if (scl_rise && state == I2C_RACK)
               begin
                  next_flag = ~pins_s.sda;
               end
               else if (scl_fall)
               begin
                  next_i2c_cnt = '0;
                  if (rw && (state == I2C_ACK || flag))
                  begin
                     next_i2c_shift = i_tx_byte;
                     i2c_take = 1'b1;
                     next_sda_oe = ~i_tx_byte[7];
                     next_state = I2C_RD;
                  end
                  else
                  begin
                     next_sda_oe = 1'b0;
                     next_state = rw ? I2C_IDLE : I2C_WR;
                  end
               end
            end
            I2C_RD:
            begin
               // next bit out on each falling clock
               if (scl_fall)
               begin
                  next_i2c_cnt = i2c_cnt + 4'h1;
                  if (i2c_cnt == I2C_BIT_LAST)
                  begin
                     next_sda_oe = 1'b0;
                     next_state = I2C_RACK;
                  end
                  else
                  begin
                     next_i2c_shift = {i2c_shift[6:0], 1'b0};
                     next_sda_oe = ~i2c_shift[6];
                  end
               end
            end
            default:
            begin
               next_state = I2C_IDLE;
            end
         endcase
      end
   end

   // count matched addresses, latch on the second
   always_comb
   begin
      next_valid_cnt = valid_cnt;
      next_latched = latched;
      next_held = held;
      if (addr_hit && !latched)
      begin
         next_valid_cnt = valid_cnt + 2'h1;
         if (valid_cnt == VALID_BEFORE_LATCH)
         begin
            next_latched = 1'b1;
            next_held = addr_live;
         end
      end
   end

   // four-wire shifter, in on rise, out on fall
   always_comb
   begin
      next_in_cnt = in_cnt;
      next_out_cnt = out_cnt;
      next_spi_in = spi_in;
      next_spi_out = spi_out;
      spi_fire = 1'b0;
      spi_take = 1'b0;
      if (!spi_on)
      begin
         next_in_cnt = '0;
         next_out_cnt = '0;
      end
      else if (cs_fall)
      begin
         next_spi_out = i_tx_byte;
         spi_take = 1'b1;
      end
      else
      begin
         if (scl_rise)
         begin
            next_spi_in = {spi_in[6:0], pins_s.sda};
            next_in_cnt = in_cnt + 3'h1;
            spi_fire = (in_cnt == SPI_BIT_LAST);
         end
         if (scl_fall)
         begin
            next_out_cnt = out_cnt + 3'h1;
            if (out_cnt == SPI_BIT_LAST)
            begin
               next_spi_out = i_tx_byte;
               spi_take = 1'b1;
            end
            else
            begin
               next_spi_out = {spi_out[6:0], 1'b0};
            end
         end
      end
      // release the output whenever chip select is high
      next_dout_oe = spi_on & ~next_spi_out[7];
   end

   // serial state registers
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= I2C_IDLE;
         i2c_cnt <= '0;
         i2c_shift <= '0;
         sda_oe <= 1'b0;
         rw <= 1'b0;
         flag <= 1'b0;
         valid_cnt <= '0;
         latched <= 1'b0;
         held <= '0;
         in_cnt <= '0;
         out_cnt <= '0;
         spi_in <= '0;
         spi_out <= '0;
         dout_oe <= 1'b0;
      end
      else
      begin
         state <= next_state;
         i2c_cnt <= next_i2c_cnt;
         i2c_shift <= next_i2c_shift;
         sda_oe <= next_sda_oe;
         rw <= next_rw;
         flag <= next_flag;
         valid_cnt <= next_valid_cnt;
         latched <= next_latched;
         held <= next_held;
         in_cnt <= next_in_cnt;
         out_cnt <= next_out_cnt;
         spi_in <= next_spi_in;
         spi_out <= next_spi_out;
         dout_oe <= next_dout_oe;
      end
   end

   // received bytes, load transfer and interrupt level
   always_comb
   begin
      next_rx.data = i2c_fire ? i2c_byte : {spi_in[6:0], pins_s.sda};
      next_rx.valid = i2c_fire | spi_fire;
      next_rx.from_i2c = i2c_fire;
      next_out_data = o_out_data;
      next_taken = '0;
      // edge copies every channel with new data
      for (int ch = 0; ch < NUM_CHAN; ch++)
      begin
         if (load_fall && i_input_new[ch])
         begin
            next_out_data[ch] = i_input_data[ch];
            next_taken[ch] = 1'b1;
         end
      end
      // pull the pin low when the asserted level is low
      next_int_oe = i_int_active_high ? ~(|i_limit_exceeded) : (|i_limit_exceeded);
   end

   assign load_fall = load_d & ~pins_s.load_n & i_strobe_pin_enable_bit;

   // output registers
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rx <= '0;
         o_out_data <= '0;
         o_input_taken <= '0;
         o_int_oe <= 1'b0;
      end
      else
      begin
         o_rx <= next_rx;
         o_out_data <= next_out_data;
         o_input_taken <= next_taken;
         o_int_oe <= next_int_oe;
      end
   end

   // open-drain pads only ever pull low
   assign o_sda_out = 1'b0;
   assign o_dout_out = 1'b0;
   assign o_int_out = 1'b0;
   assign o_sda_oe = sda_oe;
   assign o_dout_oe = dout_oe;
   assign o_tx_take = i2c_take | spi_take;
   assign o_bus_addr = addr_eff;
   assign o_addr_latched = latched;

   // checks
   chk_dout_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      pins_s.cs_n |=> !o_dout_oe) else $error("data output driven with chip select high");
   chk_addr_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(latched) |-> $past(addr_hit) && $past(valid_cnt) == VALID_BEFORE_LATCH)
      else $error("address latched at the wrong transfer");
   chk_addr_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      latched |=> latched && $stable(o_bus_addr)) else $error("latched address moved");
   chk_strap_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!latched && pins_s.strap == STRAP_HIGH) |-> o_bus_addr == ADDR_STRAP_HIGH)
      else $error("strap high gives wrong address");
   chk_load_copy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (load_fall && i_input_new[0]) |=> o_input_taken[0] && o_out_data[0] == $past(i_input_data[0]))
      else $error("load strobe did not copy channel");
   chk_load_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_strobe_pin_enable_bit |=> o_input_taken == '0) else $error("load while pin disabled");
   chk_int_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (|i_limit_exceeded && !i_int_active_high) |=> o_int_oe) else $error("interrupt not pulled low");
   chk_int_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!(|i_limit_exceeded) && !i_int_active_high) |=> !o_int_oe) else $error("interrupt pulled when idle");
   chk_i2c_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !pins_s.cs_n |=> !o_sda_oe && state == I2C_IDLE) else $error("two-wire active in four-wire frame");
   chk_spi_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_rx.valid && !o_rx.from_i2c) |-> $past(spi_on) && $past(scl_rise) && $past(in_cnt) == SPI_BIT_LAST)
      else $error("four-wire byte outside rising edge");
   cov_addr_ack: cover property (@(posedge i_clk_sys) state == I2C_ADDR ##[1:1000] state == I2C_ACK);
   cov_latch: cover property (@(posedge i_clk_sys) $rose(latched));
   cov_spi_byte: cover property (@(posedge i_clk_sys) o_rx.valid && !o_rx.from_i2c);
   cov_load: cover property (@(posedge i_clk_sys) |o_input_taken);

endmodule // dual_serial_host_port

// file: inc/host_port_pkg.sv
package host_port_pkg;

   // strap level codes from the three-level pad sense
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_FLOAT = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;

   // seven-bit two-wire addresses chosen by the strap
   localparam logic [6:0] ADDR_STRAP_LOW = 7'h48;
   localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h4a;
   localparam logic [6:0] ADDR_STRAP_HIGH = 7'h4b;

   // valid transfers seen before the one that latches the address
   localparam logic [1:0] VALID_BEFORE_LATCH = 2'h1;

   // bit counters
   localparam logic [2:0] SPI_BIT_LAST = 3'h7;
   localparam logic [3:0] I2C_BIT_LAST = 4'h7;
   localparam logic [3:0] I2C_ACK_SLOT = 4'h8;

   // converter channels behind the load strobe
   localparam int NUM_CHAN = 4;
   localparam int CHAN_WIDTH = 10;

   // least load strobe low time, in ns and in system clocks
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LOAD_MIN_NS = 20;
   localparam int LOAD_MIN_CYC = (LOAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // raw pad levels, synchronised as one bundle
   typedef struct packed {
      logic cs_n;
      logic scl;
      logic sda;
      logic load_n;
      logic [1:0] strap;
   } pin_bundle_type;

   // received byte towards the register side
   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic from_i2c;
   } rx_type;

   // one word per converter channel
   typedef logic [NUM_CHAN-1:0][CHAN_WIDTH-1:0] chan_data_type;

   // two-wire slave states
   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_WR = 3'b010,
      I2C_ACK = 3'b011,
      I2C_RD = 3'b100,
      I2C_RACK = 3'b101
   } i2c_state_type;

endpackage

// file: rtl/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   // first stage, read only by the second stage
   logic [WIDTH-1:0] meta;

   // two flops in series per bit
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         // pads idle high, so no false edge follows reset
         meta <= '1;
         o_sync <= '1;
      end
      else
      begin
         meta <= i_async;
         o_sync <= meta;
      end
   end

endmodule // sync_two_ff

// file: tb/host_serial_model.sv
`timescale 1ns/1ps
module host_serial_model
(
   // pacing clock
   input wire logic i_clk_sys,
   // resolved pad levels
   input wire logic i_sda_line,
   input wire logic i_dout_line,
   // pads driven by the host
   output logic o_cs_n,
   output logic o_scl,
   output logic o_sda_pull,
   output logic o_load_n
);
   // link clock stretch factor
   int slow = 1;

   // chip select high
   // pads idle high, two-wire mode by default
   initial
   begin
      o_cs_n = 1'b1;
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
      o_load_n = 1'b1;
   end

   // stretched bit timing
   // quarter bit: 6,7,6,6 cycles make 125 ns per bit
   task automatic qtr(input int ph);
      repeat ((ph == 1 ? 7 : 6) * slow) @(negedge i_clk_sys);
   endtask

   // two-wire bit: data set with clock low, sampled while high
   task automatic bit_io(input logic b, output logic s);
      o_sda_pull = ~b;
      qtr(0);
      o_scl = 1'b1;
      qtr(1);
      s = i_sda_line;
      qtr(2);
      o_scl = 1'b0;
      qtr(3);
   endtask

   // start or repeated start: data falls while clock high
   task automatic bus_start();
      o_sda_pull = 1'b0;
      qtr(0);
      o_scl = 1'b1;
      qtr(1);
      o_sda_pull = 1'b1;
      qtr(2);
      o_scl = 1'b0;
      qtr(3);
   endtask

   // stop: data rises while clock high, then idle
   task automatic bus_stop();
      o_sda_pull = 1'b1;
      qtr(0);
      o_scl = 1'b1;
      qtr(1);
      o_sda_pull = 1'b0;
      qtr(2);
   endtask

   // eight bits msb first, then the acknowledge slot
   task automatic i2c_byte(input logic [7:0] tx, input logic ack_bit,
                           output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(ack_bit, s);
      ack = ~s;
   endtask

   // four-wire frame
   // select low, input set before rise, output read at rise
   task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
      o_scl = 1'b0;
      qtr(0);
      o_cs_n = 1'b0;
      qtr(1);
      for (int i = 7; i >= 0; i--)
      begin
         o_sda_pull = ~tx[i];
         qtr(2);
         o_scl = 1'b1;
         rx[i] = i_dout_line;
         qtr(3);
         o_scl = 1'b0;
         qtr(0);
      end
      o_cs_n = 1'b1;
      o_sda_pull = 1'b0;
      qtr(1);
      o_scl = 1'b1;
      qtr(2);
   endtask

   // strobe low time
   // load strobe held low for the given cycles
   task automatic load_pulse(input int cyc);
      o_load_n = 1'b0;
      repeat (cyc) @(negedge i_clk_sys);
      o_load_n = 1'b1;
      repeat (6) @(negedge i_clk_sys);
   endtask
endmodule // host_serial_model

// file: tb/dual_serial_host_port_test.sv
`timescale 1ns/1ps
module dual_serial_host_port_test
   import host_port_pkg::*;
;
   // clock, reset, pads
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic cs_n, scl, sda_pull, load_n, sda_line, dout_line;
   // stimulus
   logic [1:0] strap = STRAP_FLOAT;
   logic [7:0] tx_byte = 8'h00;
   logic strobe_en = 1'b0;
   logic [NUM_CHAN-1:0] input_new = 4'h0;
   chan_data_type input_data = 40'h0;
   logic [2:0] limit = 3'h0;
   logic int_pol = 1'b0;
   // design outputs
   logic sda_out, sda_oe, dout_out, dout_oe, tx_take, addr_latched, int_out, int_oe;
   rx_type rx;
   logic [6:0] bus_addr;
   logic [NUM_CHAN-1:0] taken;
   chan_data_type out_data;
   // monitor state and counters
   logic [7:0] rx_data = 8'h00;
   logic rx_i2c = 1'b0;
   logic [NUM_CHAN-1:0] taken_acc = 4'h0;
   logic [6:0] amap [4] = '{ADDR_STRAP_LOW, ADDR_STRAP_FLOAT, ADDR_STRAP_HIGH, ADDR_STRAP_FLOAT};
   int errors = 0;
   int n_compared = 0;
   int n_taken = 0; // transmit byte hand-overs seen

   // 200 MHz clock
   always #2.5 i_clk_sys = ~i_clk_sys;

   // open-drain pads with pull-ups
   assign sda_line = ~(sda_pull | sda_oe);
   assign dout_line = ~dout_oe;

   dual_serial_host_port DUT (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(cs_n), .i_scl(scl),
      .i_sda_in(sda_line), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .o_dout_out(dout_out), .o_dout_oe(dout_oe), .i_addr_strap(strap),
      .i_tx_byte(tx_byte), .o_tx_take(tx_take), .o_rx(rx), .o_bus_addr(bus_addr),
      .o_addr_latched(addr_latched), .i_output_load_strobe_n(load_n),
      .i_strobe_pin_enable_bit(strobe_en), .i_input_new(input_new),
      .i_input_data(input_data), .o_input_taken(taken), .o_out_data(out_data),
      .i_limit_exceeded(limit), .i_int_active_high(int_pol),
      .o_int_out(int_out), .o_int_oe(int_oe));

   host_serial_model host (
      .i_clk_sys(i_clk_sys), .i_sda_line(sda_line), .i_dout_line(dout_line),
      .o_cs_n(cs_n), .o_scl(scl), .o_sda_pull(sda_pull), .o_load_n(load_n));

   // catch received bytes and copy pulses
   always @(posedge i_clk_sys)
   begin
      if (rx.valid === 1'b1)
      begin
         rx_data <= rx.data;
         rx_i2c <= rx.from_i2c;
      end
      taken_acc <= taken_acc | taken;
      if (tx_take === 1'b1)
         n_taken <= n_taken + 1;
   end

   // compare and count
   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // counts, verdict, end of run
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // two-wire write of one byte; data only sent if address acked
   task automatic i2c_write(input logic [6:0] a, input logic [7:0] d, input logic exp_ack);
      logic [7:0] rb;
      logic ack;
      host.bus_start();
      host.i2c_byte({a, 1'b0}, 1'b1, rb, ack);
      check("address ack", exp_ack, ack);
      if (ack === 1'b1)
      begin
         host.i2c_byte(d, 1'b1, rb, ack);
         check("data ack", 1'b1, ack);
         check("written byte", d, rx_data);
         check("byte from two-wire", 1'b1, rx_i2c);
      end
      host.bus_stop();
   endtask

   // hang guard
   initial
   begin
      repeat (100000) @(posedge i_clk_sys);
      errors++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      logic [7:0] rb;
      logic ack;
      repeat (4) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      check("address latched", 1'b0, addr_latched);
      check("data pad", 1'b0, sda_oe | dout_oe);
      check("interrupt idle", 1'b0, int_oe);
      check("open-drain levels", 3'h0, {sda_out, dout_out, int_out});
      for (int k = 0; k < 4; k++)
      begin
         strap = k[1:0];
         repeat (5) @(negedge i_clk_sys);
         check("strap address", amap[k], bus_addr);
      end
      $display("strap map test done");
      strap = STRAP_HIGH;
      repeat (5) @(negedge i_clk_sys);
      i2c_write(ADDR_STRAP_LOW, 8'h11, 1'b0);
      i2c_write(ADDR_STRAP_HIGH, 8'h96, 1'b1);
      check("latched after one", 1'b0, addr_latched);
      i2c_write(ADDR_STRAP_HIGH, 8'h69, 1'b1);
      check("latched after two", 1'b1, addr_latched);
      strap = STRAP_LOW;
      repeat (5) @(negedge i_clk_sys);
      check("held address", ADDR_STRAP_HIGH, bus_addr);
      i2c_write(ADDR_STRAP_LOW, 8'h22, 1'b0);
      i2c_write(ADDR_STRAP_HIGH, 8'h5f, 1'b1);
      $display("two-wire write test done");
      tx_byte = 8'hc3;
      host.slow = 4;
      host.bus_start();
      host.i2c_byte({ADDR_STRAP_HIGH, 1'b1}, 1'b1, rb, ack);
      check("read address ack", 1'b1, ack);
      host.i2c_byte(8'hff, 1'b0, rb, ack);
      check("read byte", 8'hc3, rb);
      host.i2c_byte(8'hff, 1'b1, rb, ack);
      check("second read byte", 8'hc3, rb);
      check("read bytes taken", 2, n_taken);
      host.bus_stop();
      host.slow = 1;
      $display("two-wire read test done");
      tx_byte = 8'h5a;
      host.spi_xfer(8'h3c, rb);
      check("four-wire out", 8'h5a, rb);
      check("four-wire in", 8'h3c, rx_data);
      check("byte from four-wire", 1'b0, rx_i2c);
      check("bytes taken", 4, n_taken);
      repeat (6) @(negedge i_clk_sys);
      check("output released", 1'b0, dout_oe);
      check("no two-wire drive", 1'b0, sda_oe);
      $display("four-wire test done");
      input_data = {10'h3ff, 10'h2aa, 10'h155, 10'h0f0};
      input_new = 4'h5;
      host.load_pulse(LOAD_MIN_CYC);
      check("strobe disabled", 40'h0, out_data);
      check("no copy", 4'h0, taken_acc);
      strobe_en = 1'b1;
      host.load_pulse(LOAD_MIN_CYC);
      check("loaded outputs", {10'h0, 10'h2aa, 10'h0, 10'h0f0}, out_data);
      check("copied channels", 4'h5, taken_acc);
      $display("load strobe test done");
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 8; k++)
         begin
            int_pol = p[0];
            limit = k[2:0];
            repeat (3) @(negedge i_clk_sys);
            check("interrupt drive", p[0] ^ (k != 0), int_oe);
         end
      $display("interrupt test done");
      wrap_up();
   end
endmodule // dual_serial_host_port_test
